//--- refresh_sleep_config.sv
// refresh and sleep configuration register with its self-refresh control
`timescale 1ns/1ps
`default_nettype none
`include "refresh_sleep_defines.svh"
module refresh_sleep_config
  import refresh_sleep_pkg::*;
#(
  parameter int ROW_BITS = 8,
  parameter logic [1:0] INTERVAL_CODE = `RSC_INTERVAL_4US,
  parameter int REFRESH_PERIOD_NS = 4000
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_b_in,
  input wire logic link_clock_in,
  input wire logic complementary_clock_input_in,
  input wire logic access_active_in,
  input wire logic command_address_phase_in,
  input wire logic reg_write_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic read_write_data_strobe_out,
  output logic read_write_data_strobe_oe_out,
  output logic retention_sleep_state_out,
  output logic link_clock_edge_out,
  output logic refresh_busy_out,
  output logic [ROW_BITS-1:0] refresh_row_out
);
  localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS / `RSC_CLK_PERIOD_NS;
  localparam logic [15:0] RESET_WORD = `RSC_RESET_VALUE;
  // tick spacing must not exceed the interval that the register reports
  localparam int INTERVAL_NS = (INTERVAL_CODE == `RSC_INTERVAL_1US) ? `RSC_INTERVAL_1US_NS
                                                                     : `RSC_INTERVAL_4US_NS;
  initial
  begin
    if (ROW_BITS < 4)
    begin
      $error("ROW_BITS must be at least 4");
    end
    if (REFRESH_PERIOD_NS > INTERVAL_NS)
    begin
      $error("REFRESH_PERIOD_NS longer than the reported interval");
    end
    if (INTERVAL_CODE != `RSC_INTERVAL_4US && INTERVAL_CODE != `RSC_INTERVAL_1US)
    begin
      $error("INTERVAL_CODE must be a defined interval code");
    end
    if (REFRESH_CYCLES < 2 || REFRESH_CYCLES > 65535)
    begin
      $error("REFRESH_PERIOD_NS out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] ck_sync;
    logic [1:0] ckb_sync;
    logic ck_prev;
    logic [7:0] rsvd_hi;
    logic rsvd;
    logic clk_single;
    logic sleep;
    logic [2:0] par;
    logic [15:0] interval_cnt;
    logic [2:0] busy_cnt;
    refresh_state_e rstate;
    logic strobe;
    logic strobe_oe;
    logic edge_seen;
  } state_s;

  state_s cur_reg;
  state_s cur_next;
  logic row_step;

  function automatic logic [15:0] pack_reg(input state_s s);
    pack_reg = {s.rsvd_hi, s.rsvd, s.clk_single, s.sleep, s.par, INTERVAL_CODE};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic cs_low;
    logic ck_now;
    logic want;
    cs_low = 1'b0;
    ck_now = 1'b0;
    want = 1'b0;
    cur_next = cur_reg;
    row_step = 1'b0;
    // pins pass two flops; only the second flop is read by any logic
    cur_next.cs_sync = {cur_reg.cs_sync[0], chip_select_b_in};
    cur_next.ck_sync = {cur_reg.ck_sync[0], link_clock_in};
    cur_next.ckb_sync = {cur_reg.ckb_sync[0], complementary_clock_input_in};
    cs_low = ~cur_reg.cs_sync[1];
    // in single-ended mode the complementary input never reaches edge logic
    ck_now = cur_reg.clk_single ? cur_reg.ck_sync[1]
                                : (cur_reg.ck_sync[1] & ~cur_reg.ckb_sync[1]);
    cur_next.ck_prev = ck_now;
    cur_next.edge_seen = ck_now & ~cur_reg.ck_prev;
    if (reg_write_in && !cur_reg.sleep)
    begin
      cur_next.rsvd_hi = reg_wdata_in[`RSC_RSVD_HI_MSB:`RSC_RSVD_HI_LSB];
      cur_next.rsvd = reg_wdata_in[`RSC_RSVD_BIT];
      cur_next.clk_single = reg_wdata_in[`RSC_CLK_TYPE_BIT];
      cur_next.sleep = reg_wdata_in[`RSC_SLEEP_BIT];
      cur_next.par = reg_wdata_in[`RSC_PAR_MSB:`RSC_PAR_LSB];
      // interval bits of the write data are dropped
    end
    // other fields untouched, so wake resumes the pre-sleep setup
    if (cur_reg.sleep && cs_low)
    begin
      cur_next.sleep = 1'b0;
    end
    // the tick runs through sleep too, so retained contents stay refreshed
    // refresh ticks spread evenly over the interval
    if (cur_reg.interval_cnt == 16'(REFRESH_CYCLES - 1))
    begin
      cur_next.interval_cnt = '0;
      want = (cur_reg.par != `RSC_PAR_NONE);
    end
    else
    begin
      cur_next.interval_cnt = cur_reg.interval_cnt + 16'h0001;
    end
    unique case (cur_reg.rstate)
      REF_IDLE:
      begin
        // a tick landing while a refresh is still pending is dropped
        if (want)
        begin
          cur_next.rstate = REF_WAIT;
        end
      end
      REF_WAIT:
      begin
        // wait out any active access before refreshing
        if (!access_active_in)
        begin
          cur_next.rstate = REF_BUSY;
          cur_next.busy_cnt = 3'(`RSC_REFRESH_BUSY_CYCLES - 1);
        end
      end
      REF_BUSY:
      begin
        if (cur_reg.busy_cnt == 3'h0)
        begin
          cur_next.rstate = REF_IDLE;
          row_step = 1'b1;
        end
        else
        begin
          cur_next.busy_cnt = cur_reg.busy_cnt - 3'h1;
        end
      end
      default:
      begin
        cur_next.rstate = REF_IDLE;
      end
    endcase
    // strobe is driven only in the command phase of a selected access
    cur_next.strobe_oe = command_address_phase_in && cs_low;
    // pending refresh signalled as extra latency
    cur_next.strobe = command_address_phase_in && cs_low && (cur_reg.rstate != REF_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset clears sleep and stops refresh; array contents are not protected
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cur_reg <= '{cs_sync: 2'h3,
                   ck_sync: 2'h0,
                   ckb_sync: 2'h0,
                   ck_prev: 1'b0,
                   rsvd_hi: RESET_WORD[`RSC_RSVD_HI_MSB:`RSC_RSVD_HI_LSB],
                   rsvd: RESET_WORD[`RSC_RSVD_BIT],
                   clk_single: RESET_WORD[`RSC_CLK_TYPE_BIT],
                   sleep: RESET_WORD[`RSC_SLEEP_BIT],
                   par: RESET_WORD[`RSC_PAR_MSB:`RSC_PAR_LSB],
                   interval_cnt: 16'h0000,
                   busy_cnt: 3'h0,
                   rstate: REF_IDLE,
                   strobe: 1'b0,
                   strobe_oe: 1'b0,
                   edge_seen: 1'b0};
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // rows step only as a refresh ends, so the walk stays even over the part
  refresh_row_counter #(
    .ROW_BITS(ROW_BITS)
  ) u_rows (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .step_in(row_step),
    .par_in(cur_reg.par),
    .row_out(refresh_row_out)
  );

  assign reg_rdata_out = pack_reg(cur_reg);
  assign read_write_data_strobe_out = cur_reg.strobe;
  assign read_write_data_strobe_oe_out = cur_reg.strobe_oe;
  assign retention_sleep_state_out = cur_reg.sleep;
  assign link_clock_edge_out = cur_reg.edge_seen;
  assign refresh_busy_out = (cur_reg.rstate == REF_BUSY);
endmodule
`default_nettype wire

//--- refresh_sleep_defines.svh
// constants for the refresh and sleep configuration register block
`ifndef REFRESH_SLEEP_DEFINES_SVH
`define REFRESH_SLEEP_DEFINES_SVH
`define RSC_RESET_VALUE 16'hffc1
`define RSC_RSVD_HI_MSB 15
`define RSC_RSVD_HI_LSB 8
`define RSC_RSVD_BIT 7
`define RSC_CLK_TYPE_BIT 6
`define RSC_SLEEP_BIT 5
`define RSC_PAR_MSB 4
`define RSC_PAR_LSB 2
`define RSC_INTERVAL_MSB 1
`define RSC_INTERVAL_LSB 0
`define RSC_INTERVAL_4US 2'h1
`define RSC_INTERVAL_1US 2'h2
`define RSC_PAR_FULL 3'h0
`define RSC_PAR_NONE 3'h4
`define RSC_CLK_PERIOD_NS 50
`define RSC_INTERVAL_4US_NS 4000
`define RSC_INTERVAL_1US_NS 1000
`define RSC_REFRESH_BUSY_CYCLES 4
`endif

//--- refresh_sleep_pkg.sv
// types for the refresh and sleep configuration register block
package refresh_sleep_pkg;
  typedef enum logic [1:0] {
    REF_IDLE,
    REF_WAIT,
    REF_BUSY
  } refresh_state_e;
endpackage

//--- refresh_row_counter.sv
// row counter that walks the refreshed part of the array
`timescale 1ns/1ps
`default_nettype none
module refresh_row_counter #(
  parameter int ROW_BITS = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic step_in,
  input wire logic [2:0] par_in,
  output logic [ROW_BITS-1:0] row_out
);
  initial
  begin
    if (ROW_BITS < 4)
    begin
      $error("ROW_BITS must be at least 4");
    end
  end
  logic [ROW_BITS-1:0] row_reg;
  logic [ROW_BITS-1:0] row_next;
  logic [ROW_BITS-1:0] span;
  logic [ROW_BITS-1:0] off;
  logic [ROW_BITS-1:0] low;
  always_comb
  begin
    unique case (par_in[1:0])
      2'h1: span = ROW_BITS'(1) << (ROW_BITS - 1);
      2'h2: span = ROW_BITS'(1) << (ROW_BITS - 2);
      2'h3: span = ROW_BITS'(1) << (ROW_BITS - 3);
      default: span = '0;
    endcase
    off = (par_in[2] && par_in[1:0] != 2'h0) ? ROW_BITS'(0) - span : '0;
    low = (span == '0) ? row_reg : (row_reg - off) & (span - ROW_BITS'(1));
    row_next = row_reg;
    if (step_in)
    begin
      row_next = (span == '0) ? row_reg + ROW_BITS'(1)
                              : ((low + ROW_BITS'(1)) & (span - ROW_BITS'(1))) + off;
    end
  end
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      row_reg <= '0;
    end
    else
    begin
      row_reg <= row_next;
    end
  end
  assign row_out = row_reg;
endmodule
`default_nettype wire

//--- rsc_checker_assertions.sv
// assertions on the ports of the refresh and sleep register block
`timescale 1ns/1ps
`default_nettype none
module rsc_checker #(
  parameter logic [1:0] INTERVAL_CODE = 2'h1
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_b_in,
  input wire logic access_active_in,
  input wire logic command_address_phase_in,
  input wire logic reg_write_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic read_write_data_strobe_out,
  input wire logic read_write_data_strobe_oe_out,
  input wire logic retention_sleep_state_out,
  input wire logic refresh_busy_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence busy_run;
    refresh_busy_out [*4] ##1 !refresh_busy_out;
  endsequence
  sequence woken;
    ##[2:4] !retention_sleep_state_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_interval_read_only: assert property (reg_rdata_out[1:0] == INTERVAL_CODE)
    else $error("interval field changed");
  a_reserved_ones: assert property (reg_rdata_out[15:7] == 9'h1ff)
    else $error("reserved bits not ones");
  a_write_lands: assert property (reg_write_in && !retention_sleep_state_out |=>
    reg_rdata_out[6:2] == $past(reg_wdata_in[6:2])) else $error("write lost");
  a_sleep_mirror: assert property (retention_sleep_state_out == reg_rdata_out[5])
    else $error("sleep out differs from bit");
  a_select_wakes: assert property (retention_sleep_state_out && $fell(chip_select_b_in)
    |-> woken) else $error("no wake");
  a_sleep_keeps: assert property (retention_sleep_state_out && reg_write_in |=>
    $stable({reg_rdata_out[6], reg_rdata_out[4:2]})) else $error("write taken in sleep");
  a_busy_length: assert property ($rose(refresh_busy_out) |-> busy_run)
    else $error("busy length");
  a_refresh_idle: assert property ($rose(refresh_busy_out) |-> !$past(access_active_in))
    else $error("refresh during access");
  a_strobe_cause: assert property (read_write_data_strobe_out
    |-> $past(command_address_phase_in)) else $error("strobe outside command phase");
  a_strobe_driven: assert property (read_write_data_strobe_out
    |-> read_write_data_strobe_oe_out) else $error("strobe high while not driven");
endmodule
bind refresh_sleep_config rsc_checker #(.INTERVAL_CODE(INTERVAL_CODE)) u_chk (.ref_clk_in,
  .rst_b_in, .chip_select_b_in, .access_active_in, .command_address_phase_in, .reg_write_in,
  .reg_wdata_in, .reg_rdata_out, .read_write_data_strobe_out, .retention_sleep_state_out,
  .refresh_busy_out, .read_write_data_strobe_oe_out);
`default_nettype wire

//--- host_model.sv
// host controller model: select frames and a link clock that runs only in frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic diff_in,
  output logic cs_b_out,
  output logic lclk_out,
  output logic ckb_out,
  output logic active_out,
  output logic cmd_out
);
  logic en = 1'b0;
  logic nz = 1'b0;
  initial
  begin
    cs_b_out = 1'b1;
    active_out = 1'b0;
    cmd_out = 1'b0;
    lclk_out = 1'b0;
    #37;
    forever
    begin
      #200;
      nz = ~nz;
      lclk_out = en ? ~lclk_out : 1'b0;
    end
  end
  // single-ended: complement floats, modelled as a toggling level
  assign ckb_out = diff_in ? ~lclk_out : nz;
  // len under 10 keeps select low under 4 us; len 0 is a 200 ns wake pulse
  task automatic frame(input int len);
    @(posedge clk_in);
    cs_b_out <= 1'b0;
    active_out <= len > 0;
    cmd_out <= len > 0;
    en <= len > 0;
    repeat (4) @(posedge clk_in);
    cmd_out <= 1'b0;
    repeat (len * 8) @(posedge clk_in);
    active_out <= 1'b0;
    en <= 1'b0;
    cs_b_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the refresh and sleep register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic reg_write_in = 1'b0;
  logic [15:0] reg_wdata_in = 16'hffff;
  logic diff = 1'b0;
  logic chip_select_b_in, link_clock_in, complementary_clock_input_in, access_active_in;
  logic command_address_phase_in, strobe, strobe_oe, sleep, ledge, busy;
  logic [15:0] rdata, e;
  logic [7:0] row;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int nb, ns, ne, no;
  always #25 ref_clk_in = ~ref_clk_in;
  host_model hm (.clk_in(ref_clk_in), .diff_in(diff), .cs_b_out(chip_select_b_in),
    .lclk_out(link_clock_in), .ckb_out(complementary_clock_input_in),
    .active_out(access_active_in), .cmd_out(command_address_phase_in));
  refresh_sleep_config #(.REFRESH_PERIOD_NS(1000)) uut (.ref_clk_in, .rst_b_in,
    .chip_select_b_in, .link_clock_in, .complementary_clock_input_in, .access_active_in,
    .command_address_phase_in, .reg_write_in, .reg_wdata_in, .reg_rdata_out(rdata),
    .read_write_data_strobe_out(strobe), .read_write_data_strobe_oe_out(strobe_oe),
    .retention_sleep_state_out(sleep), .link_clock_edge_out(ledge),
    .refresh_busy_out(busy), .refresh_row_out(row));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_reg(input logic c, input logic s, input logic [2:0] p);
    return {9'h1ff, c, s, p, 2'h1};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_write_in <= 1'b1;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_write_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // limit sized well above the at most about 2000 cycles the tests need
  always @(posedge ref_clk_in)
  begin
    cyc++;
    nb += busy;
    ns += strobe;
    no += strobe_oe;
    ne += ledge;
    if (cyc == 10000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(32'h7d22));
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    chk(rdata, 16'hffc1);
    ns = 0;
    no = 0;
    repeat (6)
    begin
      hm.frame(1 + $urandom % 9);
      repeat ($urandom % 30) @(posedge ref_clk_in);
    end
    // back to back frames: the long one leaves a refresh pending as the next opens
    hm.frame(9);
    hm.frame(1);
    chk(16'(ns > 0), 16'h1);
    chk(16'(no > 0), 16'h1);
    $display("access test done");
    for (int p = 0; p < 8; p++)
    begin
      e = exp_reg(1'($urandom), 1'b0, p[2:0]);
      wr({e[15:2], 2'($urandom)});
      chk(rdata, e);
      repeat (40) @(posedge ref_clk_in);
      nb = 0;
      repeat (100) @(posedge ref_clk_in);
      chk(16'(nb == 0), 16'(p == 4));
      if (p % 4 != 0)
        chk(16'(row[7]), 16'(p > 4));
    end
    $display("partial refresh test done");
    e = exp_reg(1'b1, 1'b0, 3'h5);
    wr(e | 16'h0020);
    chk(16'(sleep), 16'h1);
    wr(16'hff9c);
    chk(rdata, e | 16'h0020);
    hm.frame(0);
    repeat (5) @(posedge ref_clk_in);
    #1;
    chk(rdata, e);
    wr(e | 16'h0020);
    @(posedge ref_clk_in);
    rst_b_in <= 1'b0;
    @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    chk(rdata, 16'hffc1);
    chk(16'(sleep), 16'h0);
    $display("sleep test done");
    for (int m = 0; m < 2; m++)
    begin
      diff = m[0];
      wr(exp_reg(~m[0], 1'b0, 3'h0));
      ne = 0;
      hm.frame(5);
      repeat (8) @(posedge ref_clk_in);
      chk(16'(ne >= 5 && ne <= 6), 16'h1);
    end
    $display("clock type test done");
    wrap_up();
  end
endmodule
`default_nettype wire
